// >>> design/tas_params.svh
// Constants for the thermal alarm sensor: offsets, fields, resets, timing.
`ifndef TAS_PARAMS_SVH
`define TAS_PARAMS_SVH

// ==========================================================
// Bus address and pointer select codes
// ==========================================================
`define TAS_ADDR_FIXED 4'h9
`define TAS_PTR_TEMP   3'h0
`define TAS_PTR_CFG    3'h1
`define TAS_PTR_HYST   3'h2
`define TAS_PTR_TOS    3'h3
`define TAS_PTR_ID     3'h7

// ==========================================================
// Configuration fields and reset values
// ==========================================================
`define TAS_CFG_SHDN   0
`define TAS_CFG_MODE   1
`define TAS_CFG_POL    2
`define TAS_CFG_FQ_LO  3
`define TAS_CFG_FQ_HI  4
`define TAS_CFG_RST    8'h00
`define TAS_PTR_RST    3'h0
`define TAS_TOS_RST    12'h500
`define TAS_HYST_RST   12'h4b0

// ==========================================================
// Timing
// ==========================================================
`define TAS_CLK_MHZ    250
`define TAS_CONV_MS    100
`define TAS_TIMEOUT_MS 20
`define TAS_CONV_CYC   (`TAS_CONV_MS * 1000 * `TAS_CLK_MHZ)
`define TAS_TO_CYC     (`TAS_TIMEOUT_MS * 1000 * `TAS_CLK_MHZ)

`endif

// >>> design/tas_pkg.sv
// Types shared by the thermal alarm sensor design.
package tas_pkg;

  // ==========================================================
  // Serial front end states
  // ==========================================================
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_ACK_A = 4'h2,
    ST_PTR   = 4'h3,
    ST_ACK_W = 4'h4,
    ST_WR    = 4'h5,
    ST_RD    = 4'h6,
    ST_MACK  = 4'h7
  } tas_i2c_st_t;

  // ==========================================================
  // Whole state of the top module
  // ==========================================================
  typedef struct packed {
    tas_i2c_st_t st;
    logic [7:0]  sh;
    logic [3:0]  cnt;
    logic        rw;
    logic [1:0]  wbyte;
    logic        rbyte;
    logic [7:0]  tx;
    logic        nack;
    logic        sda_pull;
    logic        ot_pull;
    logic [2:0]  ptr;
    logic [7:0]  cfg;
    logic [11:0] tos;
    logic [11:0] hyst;
    logic [7:0]  wmsb;
    logic [11:0] temp;
    logic [11:0] tsnap;
    logic [24:0] conv_cnt;
    logic [22:0] to_cnt;
    logic        scl_q;
    logic        sda_q;
    logic        rd_clr;
  } tas_top_st_t;

endpackage : tas_pkg

// >>> design/tas_sync.sv
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module tas_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tas_sync_st_t;

  tas_sync_st_t s;
  tas_sync_st_t next_s;

  // Lines reset high, the idle level of a pulled-up bus.
  always_comb begin
    next_s    = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  // Only the second stage is visible outside.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;

endmodule : tas_sync

`default_nettype wire

// >>> design/tas_alarm.sv
// Fault queue and alarm state for comparator and interrupt modes.
`timescale 1ns/100ps
`default_nettype none

module tas_alarm
  import tas_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Conversion result and limits
  input  wire logic        conv_end_i,
  input  wire logic [11:0] temp_i,
  input  wire logic [11:0] tos_i,
  input  wire logic [11:0] hyst_i,
  // Configuration and events
  input  wire logic        int_mode_i,
  input  wire logic        shutdown_i,
  input  wire logic [1:0]  fq_sel_i,
  input  wire logic        read_clr_i,
  // Logical alarm level
  output logic             alarm_o
);

  typedef struct packed {
    logic       alarm;
    logic       dir;
    logic [2:0] cnt;
  } tas_alarm_st_t;

  tas_alarm_st_t s;
  tas_alarm_st_t next_s;
  logic          trip;
  logic          look_low;
  logic          fault;

  // Length of the fault queue for each select code.
  function automatic logic [2:0] qlen(input logic [1:0] sel);
    case (sel)
      2'h0:    qlen = 3'h1;
      2'h1:    qlen = 3'h2;
      2'h2:    qlen = 3'h4;
      default: qlen = 3'h6;
    endcase
  endfunction : qlen

  // A read clear loses to a trip in the same cycle, so no event is lost.
  always_comb begin
    next_s   = s;
    trip     = 1'b0;
    look_low = int_mode_i ? s.dir : s.alarm;
    fault    = look_low ? ($signed(temp_i) < $signed(hyst_i))
                        : ($signed(temp_i) > $signed(tos_i));
    if (conv_end_i) begin
      if (!fault) begin
        next_s.cnt = 3'h0;
      end else if (3'(s.cnt + 3'h1) >= qlen(fq_sel_i)) begin
        trip       = 1'b1;
        next_s.cnt = 3'h0;
      end else begin
        next_s.cnt = 3'(s.cnt + 3'h1);
      end
    end
    if (int_mode_i) begin
      if (read_clr_i) begin
        next_s.alarm = 1'b0;
      end
      if (trip) begin
        next_s.alarm = 1'b1;
        next_s.dir   = ~s.dir;
      end
      if (shutdown_i) begin
        next_s.alarm = 1'b0;
      end
    end else begin
      if (trip) begin
        next_s.alarm = ~s.alarm;
      end
      next_s.dir = next_s.alarm;
    end
  end

  // Power-up: no alarm, looking for the trip limit.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign alarm_o = s.alarm;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_int_read_clr: assert property (
    (int_mode_i && read_clr_i && !trip) |=> !s.alarm
  ) else $error("Interrupt alarm not cleared by a read.");

  a_int_shdn_clr: assert property (
    (int_mode_i && shutdown_i) |=> !s.alarm
  ) else $error("Interrupt alarm not cleared by shutdown.");

  a_cmp_shdn_hold: assert property (
    (!int_mode_i && shutdown_i && !conv_end_i) |=> $stable(s.alarm)
  ) else $error("Comparator alarm changed during shutdown.");

  a_queue_gate: assert property (
    $rose(s.alarm) |-> $past(conv_end_i) && $past(fault)
  ) else $error("Alarm rose without a faulted conversion.");

endmodule : tas_alarm

`default_nettype wire

// >>> design/tas_top.sv
// Thermal alarm sensor digital core: serial slave, registers, timebase, alarm pin.
//
// How it works
// - Address is 1001 followed by the three address pin levels.
// - SDA held low past the timeout drops the transfer and releases SDA.
// - Stuck timeout lies between 20 and 30 ms of SDA low.
// - No timeout release while shut down.
// - Temperature reads return the last result, conversions run undisturbed.
// - Comparator mode: set above trip limit, clear below release limit.
// - Comparator mode: shutdown leaves the alarm level as it is.
// - Interrupt mode: alarm holds until any register read completes.
// - Interrupt mode: trigger threshold alternates between trip and release.
// - Interrupt mode: shutdown clears the alarm.
// - Power-up: comparator, active low, 80 and 75 degrees, pointer zero.
// - Values are 12-bit two's complement, 0.0625 degree per step.
// - 16-bit registers hold the value in bits 15:4, low nibble reads zero.
// - Bus, limits and configuration stay usable during shutdown.
// - Alarm asserts only after the selected run of faults.
// - Fault select codes give 1, 2, 4 or 6 consecutive faults.
// - Config bits: 0 shutdown, 1 mode, 2 polarity, 4:3 fault select.
// - Alarm pin is open-drain; active-high polarity inverts the level.
// - Pointer keeps its last value and resets to zero.
// - Select 0 temp, 1 config, 2 release, 3 trip, 7 product id.
// - Writes carry address, pointer, then one or two data bytes.
// - Reads use the preset pointer, or set it then repeated start.
// - Read data goes most significant byte and bit first.
// - Ack or not-ack on the final read byte is both fine.
`timescale 1ns/100ps
`default_nettype none
`include "tas_params.svh"

module tas_top
  import tas_pkg::*;
#(
  parameter int         CONV_CYCLES = `TAS_CONV_CYC,
  parameter int         TO_CYCLES   = `TAS_TO_CYC,
  parameter logic [7:0] PROD_ID     = 8'h5c        // Arbitrary value.
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // Address pins
  input  wire logic        addr_pin_hi_i,
  input  wire logic        addr_pin_mid_i,
  input  wire logic        addr_pin_lo_i,
  // Converter side
  input  wire logic [11:0] conv_value_i,
  output logic             conv_end_o,
  output logic             shutdown_o,
  // Alarm pin
  output logic             over_temp_out_o,
  output logic             over_temp_out_oe_n_o
);

  // ==========================================================
  // Declarations
  // ==========================================================
  localparam logic [24:0] CONV_LAST = 25'(CONV_CYCLES - 1);
  localparam logic [22:0] TO_LAST   = 23'(TO_CYCLES - 1);

  localparam tas_top_st_t TOP_RST = '{
    st:    ST_IDLE,
    cfg:   `TAS_CFG_RST,
    ptr:   `TAS_PTR_RST,
    tos:   `TAS_TOS_RST,
    hyst:  `TAS_HYST_RST,
    scl_q: 1'b1,
    sda_q: 1'b1,
    default: '0
  };

  tas_top_st_t s;
  tas_top_st_t next_s;
  logic [4:0]  syn;
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  addr_s;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        shdn;
  logic        int_mode;
  logic        pol;
  logic        conv_end;
  logic        to_hit;
  logic        alarm;

  // ==========================================================
  // Helpers
  // ==========================================================

  // Left-justified half of a 12-bit value; the low nibble reads zero.
  function automatic logic [7:0] pick(input logic [11:0] v,
                                      input logic        lo);
    pick = lo ? {v[3:0], 4'h0} : v[11:4];
  endfunction : pick

  // Byte of the selected register; 8-bit registers repeat their byte.
  function automatic logic [7:0] rd_byte(input tas_top_st_t st,
                                         input logic        lo);
    case (st.ptr)
      `TAS_PTR_TEMP: rd_byte = pick(st.tsnap, lo);
      `TAS_PTR_CFG:  rd_byte = st.cfg;
      `TAS_PTR_HYST: rd_byte = pick(st.hyst, lo);
      `TAS_PTR_TOS:  rd_byte = pick(st.tos, lo);
      `TAS_PTR_ID:   rd_byte = PROD_ID;
      default:       rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // ==========================================================
  // Pin synchronisers
  // ==========================================================

  // Bus lines and address straps all come from outside the clock domain.
  tas_sync #(
    .W (5)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({scl_i, sda_i, addr_pin_hi_i, addr_pin_mid_i, addr_pin_lo_i}),
    .q_o    (syn)
  );

  // Bus events seen on the synchronised lines.
  assign scl_s  = syn[4];
  assign sda_s  = syn[3];
  assign addr_s = syn[2:0];
  assign rise   = scl_s & ~s.scl_q;
  assign fall   = ~scl_s & s.scl_q;
  assign start  = scl_s & s.scl_q & s.sda_q & ~sda_s;
  assign stop   = scl_s & s.scl_q & ~s.sda_q & sda_s;

  // Configuration fields in use.
  assign shdn     = s.cfg[`TAS_CFG_SHDN];
  assign int_mode = s.cfg[`TAS_CFG_MODE];
  assign pol      = s.cfg[`TAS_CFG_POL];

  // Conversion timebase stops in shutdown.
  assign conv_end = !shdn && (s.conv_cnt == CONV_LAST);

  // The stuck detector is off in shutdown.
  assign to_hit = !shdn && !sda_s && (s.to_cnt == TO_LAST);

  // ==========================================================
  // Alarm logic
  // ==========================================================
  tas_alarm u_alarm (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .conv_end_i (conv_end),
    .temp_i     (conv_value_i),
    .tos_i      (s.tos),
    .hyst_i     (s.hyst),
    .int_mode_i (int_mode),
    .shutdown_i (shdn),
    .fq_sel_i   (s.cfg[`TAS_CFG_FQ_HI:`TAS_CFG_FQ_LO]),
    .read_clr_i (s.rd_clr),
    .alarm_o    (alarm)
  );

  // ==========================================================
  // Next state
  // ==========================================================

  // Timebase, stuck detector and serial slave; bits sample on SCL rise
  // and SDA changes on SCL fall, so our own drive never mimics a start.
  always_comb begin
    next_s        = s;
    next_s.scl_q  = scl_s;
    next_s.sda_q  = sda_s;
    next_s.rd_clr = 1'b0;

    // Result capture happens only at the end of a conversion.
    if (shdn) begin
      next_s.conv_cnt = 25'h0;
    end else if (conv_end) begin
      next_s.conv_cnt = 25'h0;
      next_s.temp     = conv_value_i;
    end else begin
      next_s.conv_cnt = 25'(s.conv_cnt + 25'h1);
    end

    // Count continuous SDA low time; saturate once the limit is reached.
    if (shdn || sda_s) begin
      next_s.to_cnt = 23'h0;
    end else if (s.to_cnt != TO_LAST) begin
      next_s.to_cnt = 23'(s.to_cnt + 23'h1);
    end

    // Open-drain alarm: pull low when the logical level asks for low.
    next_s.ot_pull = alarm ^ pol;

    if (to_hit) begin
      next_s.st       = ST_IDLE;
      next_s.sda_pull = 1'b0;
    end else if (start) begin
      next_s.st       = ST_ADDR;
      next_s.cnt      = 4'h0;
      next_s.sda_pull = 1'b0;
    end else if (stop) begin
      next_s.st       = ST_IDLE;
      next_s.sda_pull = 1'b0;
    end else if (rise) begin
      case (s.st)
        ST_ADDR, ST_PTR, ST_WR: begin
          next_s.sh  = {s.sh[6:0], sda_s};
          next_s.cnt = 4'(s.cnt + 4'h1);
        end
        ST_RD: begin
          next_s.cnt = 4'(s.cnt + 4'h1);
        end
        ST_MACK: begin
          next_s.nack = sda_s;
        end
        default: begin
          next_s.cnt = s.cnt;
        end
      endcase
    end else if (fall) begin
      case (s.st)
        ST_ADDR: begin
          if (s.cnt == 4'h8) begin
            if (s.sh[7:1] == {`TAS_ADDR_FIXED, addr_s}) begin
              next_s.st       = ST_ACK_A;
              next_s.sda_pull = 1'b1;
              next_s.rw       = s.sh[0];
              next_s.tsnap    = s.temp;
            end else begin
              next_s.st = ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          next_s.cnt = 4'h0;
          if (s.rw) begin
            next_s.st       = ST_RD;
            next_s.tx       = rd_byte(s, 1'b0);
            next_s.sda_pull = ~next_s.tx[7];
            next_s.rbyte    = 1'b1;
          end else begin
            next_s.st       = ST_PTR;
            next_s.sda_pull = 1'b0;
          end
        end
        ST_PTR: begin
          if (s.cnt == 4'h8) begin
            next_s.ptr      = s.sh[2:0];
            next_s.wbyte    = 2'h0;
            next_s.st       = ST_ACK_W;
            next_s.sda_pull = 1'b1;
          end
        end
        ST_ACK_W: begin
          next_s.st       = ST_WR;
          next_s.cnt      = 4'h0;
          next_s.sda_pull = 1'b0;
        end
        ST_WR: begin
          if (s.cnt == 4'h8) begin
            next_s.st       = ST_ACK_W;
            next_s.sda_pull = 1'b1;
            if (s.wbyte != 2'h2) begin
              next_s.wbyte = 2'(s.wbyte + 2'h1);
            end
            // Writes are honoured in shutdown; read-only codes drop data.
            case (s.ptr)
              `TAS_PTR_CFG: begin
                if (s.wbyte == 2'h0) begin
                  next_s.cfg = s.sh;
                end
              end
              `TAS_PTR_HYST: begin
                if (s.wbyte == 2'h0) begin
                  next_s.wmsb = s.sh;
                end else if (s.wbyte == 2'h1) begin
                  next_s.hyst = {s.wmsb, s.sh[7:4]};
                end
              end
              `TAS_PTR_TOS: begin
                if (s.wbyte == 2'h0) begin
                  next_s.wmsb = s.sh;
                end else if (s.wbyte == 2'h1) begin
                  next_s.tos = {s.wmsb, s.sh[7:4]};
                end
              end
              default: begin
                next_s.wmsb = s.wmsb;
              end
            endcase
          end
        end
        ST_RD: begin
          if (s.cnt == 4'h8) begin
            next_s.st       = ST_MACK;
            next_s.sda_pull = 1'b0;
            next_s.rd_clr   = 1'b1;
          end else begin
            next_s.tx       = {s.tx[6:0], 1'b0};
            next_s.sda_pull = ~s.tx[6];
          end
        end
        ST_MACK: begin
          // A not-ack simply ends our part; the master then sends stop.
          if (s.nack) begin
            next_s.st = ST_IDLE;
          end else begin
            next_s.st       = ST_RD;
            next_s.cnt      = 4'h0;
            next_s.tx       = rd_byte(s, s.rbyte);
            next_s.sda_pull = ~next_s.tx[7];
            next_s.rbyte    = ~s.rbyte;
          end
        end
        default: begin
          next_s.sda_pull = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  // ==========================================================

  // Power-up defaults load from constants only.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= TOP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================

  // Both pins are open-drain: data is always low, the enable does the work.
  assign sda_o                = 1'b0;
  assign sda_oe_n_o           = ~s.sda_pull;
  assign over_temp_out_o      = 1'b0;
  assign over_temp_out_oe_n_o = ~s.ot_pull;
  assign conv_end_o           = conv_end;
  assign shutdown_o           = shdn;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_addr_mismatch: assert property (
    (s.st == ST_ADDR && fall && s.cnt == 4'h8 && !to_hit &&
     s.sh[7:1] != {`TAS_ADDR_FIXED, addr_s}) |=> s.st == ST_IDLE && !s.sda_pull
  ) else $error("Foreign address was not ignored.");

  a_stuck_release: assert property (
    to_hit |=> (s.st == ST_IDLE && sda_oe_n_o)
  ) else $error("Stuck SDA did not release the slave.");

  a_timeout_off: assert property (
    shdn |=> s.to_cnt == 23'h0
  ) else $error("Stuck timer ran during shutdown.");

  a_temp_hold: assert property (
    !conv_end |=> $stable(s.temp)
  ) else $error("Temperature changed outside a conversion end.");

  a_pin_polarity: assert property (
    1'b1 |=> over_temp_out_oe_n_o == !($past(alarm) ^ $past(pol))
  ) else $error("Alarm pin does not follow level and polarity.");

  a_ptr_hold: assert property (
    $changed(s.ptr) |-> $past(s.st) == ST_PTR && $past(fall)
  ) else $error("Pointer changed outside a pointer byte.");

endmodule : tas_top

`default_nettype wire

// >>> sim/tas_master.sv
// Two-wire bus master model that clocks the sensor's serial port.
`timescale 1ns/100ps
`default_nettype none

module tas_master (
  // Resolved data line
  input  wire logic sda_i,
  // Clock line and data pull-down
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ==========================================================
  // Bus phases, 80 ns per bit
  // ==========================================================
  // Clock starts driven high and data released; the bench pull-up makes data high.
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    #20 sda_pull_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_pull_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask : start

  // Stop: data rises while the clock is high.
  task automatic stop();
    #20 sda_pull_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 sda_pull_o = 1'b0;
    #40;
  endtask : stop

  // One bit; data only moves while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    #20 sda_pull_o = ~b;
    #20 scl_o = 1'b1;
    #20 r = sda_i;
    #20 scl_o = 1'b0;
  endtask : bit_x

  // Byte out, most significant bit first, then the slave's ack.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // Byte in; the master acks or not as told.
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(~mack, r);
  endtask : rd_byte
endmodule : tas_master
`default_nettype wire

// >>> sim/thermal_alarm_sensor_i2c_slave_bench.sv
// Self-checking bench for the thermal alarm sensor core.
`timescale 1ns/100ps
`default_nettype none

module thermal_alarm_sensor_i2c_slave_bench;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [2:0]  apin = 3'h0;
  logic [11:0] conv = 12'h123;
  logic        scl;
  logic        pull;
  logic        sda_oe_n;
  logic        conv_end;
  logic        shdn;
  logic        ot_en_n;
  logic        ot_do;
  logic        sdo;
  logic [15:0] d;
  logic [15:0] e;
  logic        a;
  int          n;
  int          error_cnt = 0;
  int          total_checks = 0;
  // Open-drain data and alarm lines, each with a pull-up.
  wire logic   sda = ~pull & (sda_oe_n | sdo);
  wire logic   ot_oe_n = ot_en_n | ot_do;

  // ==========================================================
  // Design, master model and clock
  // ==========================================================
  // Short conversion and timeout counts keep the run brief.
  tas_top #(.CONV_CYCLES(1000), .TO_CYCLES(1000), .PROD_ID(8'h3a)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_n_o(sda_oe_n), .addr_pin_hi_i(apin[2]), .addr_pin_mid_i(apin[1]),
    .addr_pin_lo_i(apin[0]), .conv_value_i(conv), .conv_end_o(conv_end),
    .shutdown_o(shdn), .over_temp_out_o(ot_do), .over_temp_out_oe_n_o(ot_en_n));
  tas_master i_mst (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

  // Clock of 4 ns.
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [15:0] reg16(input logic [11:0] v);
    return {v, 4'h0};
  endfunction : reg16

  function automatic int nflt(input logic [1:0] c);
    return (c == 2'h0) ? 1 : (c == 2'h1) ? 2 : (c == 2'h2) ? 4 : 6;
  endfunction : nflt

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    total_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // Waits for n conversion ends, with a bound.
  task automatic wconv(input int c);
    int k;
    k = 0;
    while (c > 0) begin
      @(posedge clk_i);
      #1;
      k++;
      if (conv_end === 1'b1) c--;
      if (k > 20000) begin
        error_cnt++;
        finish_test();
      end
    end
  endtask : wconv

  // Sets the converter value, waits, lets the pin settle.
  task automatic conv_at(input logic [11:0] v, input int c);
    conv = v;
    wconv(c);
    repeat (3) @(posedge clk_i);
    #1;
  endtask : conv_at

  task automatic wr(input logic [2:0] p, input logic [15:0] v, input int nb);
    logic k;
    logic ok;
    i_mst.start();
    i_mst.wr_byte({4'h9, apin, 1'b0}, ok);
    i_mst.wr_byte({5'h00, p}, k);
    ok &= k;
    if (nb == 2) i_mst.wr_byte(v[15:8], k);
    if (nb == 2) ok &= k;
    i_mst.wr_byte(v[7:0], k);
    i_mst.stop();
    chk(16'(ok & k), 16'h0001);
  endtask : wr

  task automatic rd(input logic set, input logic [2:0] p, input int nb,
                    output logic [15:0] v);
    logic [7:0] b;
    v = 16'h0000;
    if (set) begin
      i_mst.start();
      i_mst.wr_byte({4'h9, apin, 1'b0}, a);
      i_mst.wr_byte({5'h00, p}, a);
    end
    i_mst.start();
    i_mst.wr_byte({4'h9, apin, 1'b1}, a);
    chk(16'(a), 16'h0001);
    for (int i = 0; i < nb; i++) begin
      i_mst.rd_byte(i < nb - 1, b);
      v = {v[7:0], b};
    end
    i_mst.stop();
  endtask : rd

  // Master stalls with the clock low while the slave holds data low.
  task automatic hang(input logic [7:0] cfg, input logic x);
    logic r;
    wr(3'h1, {8'h00, cfg}, 1);
    i_mst.start();
    i_mst.wr_byte({4'h9, apin, 1'b1}, a);
    repeat (900) @(posedge clk_i);
    chk(16'(sda), 16'h0000);
    repeat (200) @(posedge clk_i);
    #1;
    chk(16'(sda), 16'(x));
    repeat (8) i_mst.bit_x(1'b1, r);
    i_mst.stop();
  endtask : hang

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    void'($urandom(49));
    apin = 3'($urandom());
    repeat (5) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    wconv(1);
    rd(0, 3'h0, 2, d);
    chk(d, reg16(12'h123));
    chk(16'(ot_oe_n), 16'h0001);
    rd(1, 3'h1, 1, d);
    chk(d, 16'h0000);
    rd(1, 3'h3, 2, d);
    chk(d, reg16(12'h500));
    rd(1, 3'h2, 2, d);
    chk(d, reg16(12'h4b0));
    rd(1, 3'h7, 1, d);
    chk(d, 16'h003a);
    rd(1, 3'h5, 1, d);
    chk(d, 16'h0000);
    i_mst.start();
    i_mst.wr_byte({4'h9, ~apin, 1'b0}, a);
    i_mst.stop();
    chk(16'(a), 16'h0000);
    // Temperature readout, full and partial, with the sign corner.
    for (int i = 0; i < 4; i++) begin
      conv = (i == 0) ? 12'h800 : 12'($urandom());
      wconv(1);
      rd(1, 3'h0, 2, d);
      chk(d, reg16(conv));
      rd(0, 3'h0, 1, d);
      chk(d, {8'h00, conv[11:4]});
      d = reg16(12'($urandom()));
      wr(3'(2 + i % 2), d, 2);
      rd(1, 3'(2 + i % 2), 2, e);
      chk(e, d);
    end
    wr(3'h0, 16'hfff0, 2);
    rd(1, 3'h0, 2, d);
    chk(d, reg16(conv));
    // Comparator mode and every fault count.
    wr(3'h3, reg16(12'h100), 2);
    wr(3'h2, reg16(12'h0f0), 2);
    for (int c = 3; c >= 0; c--) begin
      wr(3'h1, {11'h000, 2'(c), 3'h0}, 1);
      conv_at(12'h000, 7);
      n = 0;
      while (ot_oe_n !== 1'b0 && n < 8) begin
        conv_at(12'h101, 1);
        n++;
      end
      chk(16'(n), 16'(nflt(2'(c))));
    end
    conv_at(12'h0f0, 2);
    chk(16'(ot_oe_n), 16'h0000);
    conv_at(12'h0ef, 1);
    chk(16'(ot_oe_n), 16'h0001);
    conv_at(12'h100, 2);
    chk(16'(ot_oe_n), 16'h0001);
    wr(3'h1, 16'h0008, 1);
    conv_at(12'h101, 1);
    conv_at(12'h050, 1);
    conv_at(12'h101, 1);
    chk(16'(ot_oe_n), 16'h0001);
    conv_at(12'h101, 1);
    chk(16'(ot_oe_n), 16'h0000);
    wr(3'h1, 16'h0009, 1);
    chk(16'(ot_oe_n), 16'h0000);
    wr(3'h1, 16'h000c, 1);
    repeat (3) @(posedge clk_i);
    #1;
    chk(16'(ot_oe_n), 16'h0001);
    // Interrupt mode.
    wr(3'h1, 16'h0000, 1);
    conv_at(12'h000, 2);
    wr(3'h1, 16'h0002, 1);
    conv_at(12'h101, 3);
    chk(16'(ot_oe_n), 16'h0000);
    rd(1, 3'h2, 1, d);
    chk(16'(ot_oe_n), 16'h0001);
    conv_at(12'h101, 2);
    chk(16'(ot_oe_n), 16'h0001);
    conv_at(12'h000, 1);
    chk(16'(ot_oe_n), 16'h0000);
    wr(3'h1, 16'h0003, 1);
    repeat (3) @(posedge clk_i);
    #1;
    chk(16'(ot_oe_n), 16'h0001);
    chk(16'(shdn), 16'h0001);
    rd(1, 3'h1, 1, d);
    chk(d, 16'h0003);
    hang(8'h03, 1'b0);
    hang(8'h00, 1'b1);
    finish_test();
  end
endmodule : thermal_alarm_sensor_i2c_slave_bench
`default_nettype wire
